// file: hw/pllc_load_port.sv
// counter load port: serial, parallel and direct programming, monitors, lock
//
// The Wishbone slave port and the register addresses were chosen for this implementation.
`timescale 1ns/10ps
// Functional notes
// - serial mode, enhancement write high: shift serial bit into enhancement register
// - parallel mode: enhancement write strobe rise loads all eight bus bits
// - main-high strobe rise loads bus bits 3..0 into ref 5..4, main 8..7
// - direct select high forces direct mode, counters from hardwired pins
// - main-low strobe rise loads prescaler enable and main bits 6..0
// - swallow strobe rise loads ref bits 3..0 and swallow bits 3..0
// - hop strobe rise copies primary into secondary outside direct mode
// - main divider monitor output, held quiet when enhancement disables it
// - reference divider monitor output, silenced likewise by enhancement setting
// - test output carries modulus select or raw prescaler per enhancement bits
// - lock filter node is nand of up and down pulse outputs
// - down pulse goes low while main divider leads reference
// - up pulse goes low while reference divider leads main
// - lock indicator open drain: released when locked, driven low otherwise
// - enhancement bits act only while active-low enhancement input is low
// - serial, both write lines low: shift primary msb first on clock rise
// - serial mode: serial load rise copies primary into secondary
// - counters use primary when choice input is 1, secondary when 0
module pllc_load_port (
   // clock and reset
   input  wire logic                clk,
   input  wire logic                rst,
   // wishbone slave
   input  wire logic                wb_cyc_i,
   input  wire logic                wb_stb_i,
   input  wire logic                wb_we_i,
   input  wire logic [7:0]          wb_adr_i,
   input  wire logic [3:0]          wb_sel_i,
   input  wire logic [31:0]         wb_dat_i,
   output logic      [31:0]         wb_dat_o,
   output logic                     wb_ack_o,
   // mode pins
   input  wire logic                serial_mode_sel,
   input  wire logic                direct_mode_sel,
   input  wire logic                enh_mode_n,
   input  wire logic                parallel_register_choice,
   input  wire logic                serial_register_choice,
   // parallel strobes and bus
   input  wire logic                main_count_low_strobe,
   input  wire logic                main_count_high_strobe,
   input  wire logic                swallow_count_strobe,
   input  wire logic                enh_write,
   input  wire logic                hop_strobe,
   input  wire logic [7:0]          par_data,
   // serial pins
   input  wire logic                serial_load,
   input  wire logic                shift_clk,
   input  wire logic                shift_data,
   // hardwired counter pins
   input  wire pllc_pkg::pllc_cfg_s direct_cfg,
   // divider side
   input  wire logic                main_divider_in,
   input  wire logic                reference_divider_in,
   input  wire logic                modulus_select,
   input  wire logic                prescaler_raw,
   // counter programming and outputs
   output pllc_pkg::pllc_cfg_s      counter_cfg,
   output logic                     main_divider_monitor,
   output logic                     reference_divider_monitor,
   output logic                     test_data_out,
   output logic                     phase_down_pulse_n,
   output logic                     phase_up_pulse_n,
   output logic                     lock_filter,
   output logic                     lock_indicator_o,
   output logic                     lock_indicator_oe
);
   typedef struct packed {
      pllc_pkg::pllc_pins_s prev;
      pllc_pkg::pllc_cfg_s  primary;
      pllc_pkg::pllc_cfg_s  secondary;
      logic [7:0]           enh;
      pllc_pkg::pllc_cfg_s  cfg;
      logic                 mon_main;
      logic                 mon_ref;
      logic                 dout;
      logic                 soft_hop;
      logic                 ack;
      logic [31:0]          dat;
   } pllc_st_s;

   pllc_st_s             st_q;
   pllc_st_s             st_d;
   pllc_pkg::pllc_pins_s raw;
   pllc_pkg::pllc_pins_s pin;
   logic                 direct;
   logic                 serial;
   logic                 parallel;
   logic                 enh_on;
   logic                 main_rise;
   logic                 ref_rise;
   logic                 shift_rise;
   logic                 hop_go;
   logic                 bus_req;

   function automatic logic rise(input logic cur, input logic prev);
      rise = cur & ~prev;
   endfunction : rise

   function automatic logic [31:0] cfg_word(input pllc_pkg::pllc_cfg_s c);
      cfg_word = {12'h000, c};
   endfunction : cfg_word

   assign raw = '{serial_mode: serial_mode_sel, direct_mode: direct_mode_sel,
                  enh_mode_n: enh_mode_n, par_choice: parallel_register_choice,
                  ser_choice: serial_register_choice, m_low_wr: main_count_low_strobe,
                  m_high_wr: main_count_high_strobe, swallow_wr: swallow_count_strobe,
                  enh_wr: enh_write, hop_wr: hop_strobe, serial_load: serial_load,
                  shift_clk: shift_clk, shift_data: shift_data, par_data: par_data,
                  direct_cfg: direct_cfg, main_div: main_divider_in,
                  ref_div: reference_divider_in, mod_sel: modulus_select,
                  presc_raw: prescaler_raw};

   pllc_sync #(
      .WIDTH (pllc_pkg::SYNC_W)
   ) u_sync (
      .clk      (clk),
      .rst      (rst),
      .async_in (raw),
      .sync_out (pin)
   );

   assign direct     = pin.direct_mode;
   assign serial     = ~pin.direct_mode & pin.serial_mode;
   assign parallel   = ~pin.direct_mode & ~pin.serial_mode;
   assign enh_on     = ~pin.direct_mode & ~pin.enh_mode_n;
   assign main_rise  = rise(pin.main_div, st_q.prev.main_div);
   assign ref_rise   = rise(pin.ref_div, st_q.prev.ref_div);
   assign shift_rise = serial & rise(pin.shift_clk, st_q.prev.shift_clk);
   assign hop_go     = ~direct & (rise(pin.hop_wr, st_q.prev.hop_wr) | st_q.soft_hop);
   assign bus_req    = wb_cyc_i & wb_stb_i & ~st_q.ack;

   always_comb begin
      st_d          = st_q;
      st_d.prev     = pin;
      st_d.soft_hop = 1'b0;
      // serial shifting; direct mode never reaches here
      if (shift_rise && pin.enh_wr) begin
         st_d.enh = {st_q.enh[6:0], pin.shift_data};
      end else if (shift_rise && !pin.serial_load) begin
         st_d.primary = {st_q.primary[18:0], pin.shift_data};
      end
      // parallel field writes
      if (parallel && rise(pin.enh_wr, st_q.prev.enh_wr)) begin
         st_d.enh = pin.par_data;
      end
      if (parallel && rise(pin.m_low_wr, st_q.prev.m_low_wr)) begin
         st_d.primary.presc_en        = pin.par_data[7];
         st_d.primary.main_count[6:0] = pin.par_data[6:0];
      end
      if (parallel && rise(pin.m_high_wr, st_q.prev.m_high_wr)) begin
         st_d.primary.ref_count[5:4]  = pin.par_data[3:2];
         st_d.primary.main_count[8:7] = pin.par_data[1:0];
      end
      if (parallel && rise(pin.swallow_wr, st_q.prev.swallow_wr)) begin
         st_d.primary.ref_count[3:0]     = pin.par_data[7:4];
         st_d.primary.swallow_count[3:0] = pin.par_data[3:0];
      end
      // secondary copy takes the primary as it stood before this cycle's writes
      if (hop_go || (serial && rise(pin.serial_load, st_q.prev.serial_load))) begin
         st_d.secondary = st_q.primary;
      end
      // counter source selection
      if (direct) begin
         st_d.cfg = pin.direct_cfg;
      end else if (serial ? pin.ser_choice : pin.par_choice) begin
         st_d.cfg = st_q.primary;
      end else begin
         st_d.cfg = st_q.secondary;
      end
      // monitors hold low when silenced
      st_d.mon_main = pin.main_div & ~(enh_on & st_q.enh[pllc_pkg::ENH_MAIN_OFF]);
      st_d.mon_ref  = pin.ref_div & ~(enh_on & st_q.enh[pllc_pkg::ENH_REF_OFF]);
      if (enh_on && st_q.enh[pllc_pkg::ENH_DOUT_EN]) begin
         st_d.dout = st_q.enh[pllc_pkg::ENH_DOUT_SEL] ? pin.presc_raw : pin.mod_sel;
      end else begin
         st_d.dout = 1'b0;
      end
      // wishbone: one wait state, ack for one cycle
      st_d.ack = bus_req;
      st_d.dat = 32'h0000_0000;
      if (bus_req && wb_we_i && wb_adr_i == pllc_pkg::OFS_CTRL && wb_sel_i[0]) begin
         st_d.soft_hop = wb_dat_i[pllc_pkg::CTRL_SOFT_HOP];
      end
      if (bus_req && !wb_we_i) begin
         case (wb_adr_i)
            pllc_pkg::OFS_PRIMARY:   st_d.dat = cfg_word(st_q.primary);
            pllc_pkg::OFS_SECONDARY: st_d.dat = cfg_word(st_q.secondary);
            pllc_pkg::OFS_ENH:       st_d.dat = {24'h000000, st_q.enh};
            pllc_pkg::OFS_ACTIVE:    st_d.dat = cfg_word(st_q.cfg);
            pllc_pkg::OFS_STATUS: begin
               st_d.dat[pllc_pkg::ST_SERIAL] = serial;
               st_d.dat[pllc_pkg::ST_DIRECT] = direct;
               st_d.dat[pllc_pkg::ST_ENH_ON] = enh_on;
               st_d.dat[pllc_pkg::ST_LOCKED] = ~lock_filter;
            end
            default:                 st_d.dat = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         st_q           <= '0;
         st_q.primary   <= pllc_pkg::PRIMARY_RST;
         st_q.secondary <= pllc_pkg::PRIMARY_RST;
         st_q.cfg       <= pllc_pkg::PRIMARY_RST;
         st_q.enh       <= pllc_pkg::ENH_RST;
      end else begin
         st_q <= st_d;
      end
   end

   pllc_phase_det u_pd (
      .clk         (clk),
      .rst         (rst),
      .ref_rise    (ref_rise),
      .main_rise   (main_rise),
      .up_n        (phase_up_pulse_n),
      .down_n      (phase_down_pulse_n),
      .lock_filter (lock_filter),
      .lock_oe     (lock_indicator_oe)
   );

   assign lock_indicator_o          = 1'b0;
   assign wb_dat_o                  = st_q.dat;
   assign wb_ack_o                  = st_q.ack;
   assign counter_cfg               = st_q.cfg;
   assign main_divider_monitor      = st_q.mon_main;
   assign reference_divider_monitor = st_q.mon_ref;
   assign test_data_out             = st_q.dout;

   a_enh_parallel: assert property (@(posedge clk) disable iff (rst)
      parallel && rise(pin.enh_wr, st_q.prev.enh_wr) |=> st_q.enh == $past(pin.par_data))
      else $error("enhancement register missed parallel load");
   a_main_high: assert property (@(posedge clk) disable iff (rst)
      parallel && rise(pin.m_high_wr, st_q.prev.m_high_wr)
      |=> st_q.primary.main_count[8:7] == $past(pin.par_data[1:0])
          && st_q.primary.ref_count[5:4] == $past(pin.par_data[3:2]))
      else $error("main high field load wrong");
   a_main_low: assert property (@(posedge clk) disable iff (rst)
      parallel && rise(pin.m_low_wr, st_q.prev.m_low_wr)
      |=> {st_q.primary.presc_en, st_q.primary.main_count[6:0]} == $past(pin.par_data))
      else $error("main low field load wrong");
   a_swallow: assert property (@(posedge clk) disable iff (rst)
      parallel && rise(pin.swallow_wr, st_q.prev.swallow_wr)
      |=> {st_q.primary.ref_count[3:0], st_q.primary.swallow_count} == $past(pin.par_data))
      else $error("swallow field load wrong");
   a_hop_copy: assert property (@(posedge clk) disable iff (rst)
      hop_go |=> st_q.secondary == $past(st_q.primary)) else $error("hop copy missed");
   a_serial_copy: assert property (@(posedge clk) disable iff (rst)
      serial && rise(pin.serial_load, st_q.prev.serial_load)
      |=> st_q.secondary == $past(st_q.primary)) else $error("serial load copy missed");
   a_primary_shift: assert property (@(posedge clk) disable iff (rst)
      shift_rise && !pin.enh_wr && !pin.serial_load
      |=> st_q.primary == {$past(st_q.primary[18:0]), $past(pin.shift_data)})
      else $error("primary shift wrong");
   a_enh_shift: assert property (@(posedge clk) disable iff (rst)
      shift_rise && pin.enh_wr |=> st_q.enh == {$past(st_q.enh[6:0]), $past(pin.shift_data)})
      else $error("enhancement shift wrong");
   a_direct_hold: assert property (@(posedge clk) disable iff (rst)
      direct && $past(direct) |=> $stable(st_q.primary) && $stable(st_q.enh))
      else $error("direct mode changed a register");
   a_direct_cfg: assert property (@(posedge clk) disable iff (rst)
      direct |=> counter_cfg == $past(pin.direct_cfg)) else $error("direct pins not used");
   a_choice_sel: assert property (@(posedge clk) disable iff (rst)
      parallel && !pin.par_choice |=> counter_cfg == $past(st_q.secondary))
      else $error("secondary not selected");
   a_monitor_off: assert property (@(posedge clk) disable iff (rst)
      enh_on && st_q.enh[pllc_pkg::ENH_MAIN_OFF] |=> !main_divider_monitor)
      else $error("main monitor not silenced");
   a_ref_monitor: assert property (@(posedge clk) disable iff (rst)
      !enh_on |=> reference_divider_monitor == $past(pin.ref_div))
      else $error("reference monitor does not follow divider");
   a_dout_route: assert property (@(posedge clk) disable iff (rst)
      enh_on && st_q.enh[pllc_pkg::ENH_DOUT_EN] && !st_q.enh[pllc_pkg::ENH_DOUT_SEL]
      |=> test_data_out == $past(pin.mod_sel)) else $error("test output not modulus select");
   a_enh_gate: assert property (@(posedge clk) disable iff (rst)
      pin.enh_mode_n |=> !test_data_out && main_divider_monitor == $past(pin.main_div))
      else $error("enhancement bits acted while disabled");
   a_direct_ignore: assert property (@(posedge clk) disable iff (rst)
      direct |=> $stable(st_q.secondary))
      else $error("direct mode changed the secondary register");
   a_serial_choice: assert property (@(posedge clk) disable iff (rst)
      serial && pin.ser_choice |=> counter_cfg == $past(st_q.primary))
      else $error("primary not selected in serial mode");
   a_primary_src: assert property (@(posedge clk) disable iff (rst)
      parallel && pin.par_choice |=> counter_cfg == $past(st_q.primary))
      else $error("primary not selected in parallel mode");
   a_ref_off: assert property (@(posedge clk) disable iff (rst)
      enh_on && st_q.enh[pllc_pkg::ENH_REF_OFF] |=> !reference_divider_monitor)
      else $error("reference monitor not silenced");
   a_dout_raw: assert property (@(posedge clk) disable iff (rst)
      enh_on && st_q.enh[pllc_pkg::ENH_DOUT_EN] && st_q.enh[pllc_pkg::ENH_DOUT_SEL]
      |=> test_data_out == $past(pin.presc_raw)) else $error("test output not raw prescaler");
endmodule : pllc_load_port

// file: hw/pllc_pkg.sv
// shared types and constants of the synthesizer load port
package pllc_pkg;
   // counter settings word, first field shifted in first (msb first)
   typedef struct packed {
      logic [5:0] ref_count;
      logic       presc_en;
      logic [8:0] main_count;
      logic [3:0] swallow_count;
   } pllc_cfg_s;

   // every pin input, gathered so it can pass the synchroniser in one piece
   typedef struct packed {
      logic       serial_mode;
      logic       direct_mode;
      logic       enh_mode_n;
      logic       par_choice;
      logic       ser_choice;
      logic       m_low_wr;
      logic       m_high_wr;
      logic       swallow_wr;
      logic       enh_wr;
      logic       hop_wr;
      logic       serial_load;
      logic       shift_clk;
      logic       shift_data;
      logic [7:0] par_data;
      pllc_cfg_s  direct_cfg;
      logic       main_div;
      logic       ref_div;
      logic       mod_sel;
      logic       presc_raw;
   } pllc_pins_s;

   localparam int unsigned PRIMARY_W = 20;
   localparam int unsigned ENH_W     = 8;
   localparam int unsigned SYNC_W    = $bits(pllc_pins_s);

   // register byte offsets
   localparam logic [7:0] OFS_CTRL      = 8'h00;
   localparam logic [7:0] OFS_PRIMARY   = 8'h04;
   localparam logic [7:0] OFS_SECONDARY = 8'h08;
   localparam logic [7:0] OFS_ENH       = 8'h0C;
   localparam logic [7:0] OFS_ACTIVE    = 8'h10;
   localparam logic [7:0] OFS_STATUS    = 8'h14;

   // field positions
   localparam int unsigned CTRL_SOFT_HOP = 0;
   localparam int unsigned ENH_DOUT_SEL  = 0;
   localparam int unsigned ENH_DOUT_EN   = 1;
   localparam int unsigned ENH_MAIN_OFF  = 2;
   localparam int unsigned ENH_REF_OFF   = 3;
   localparam int unsigned ST_SERIAL     = 0;
   localparam int unsigned ST_DIRECT     = 1;
   localparam int unsigned ST_ENH_ON     = 2;
   localparam int unsigned ST_LOCKED     = 3;

   // reset values
   localparam logic [19:0] PRIMARY_RST = 20'h00000;
   localparam logic [7:0]  ENH_RST     = 8'h00;
endpackage : pllc_pkg

// file: hw/pllc_sync.sv
// two-stage synchroniser for a bundle of pin inputs
`timescale 1ns/10ps
module pllc_sync #(
   parameter int unsigned WIDTH = 1
) (
   // clock and reset
   input  wire logic             clk,
   input  wire logic             rst,
   // pins and synchronised copy
   input  wire logic [WIDTH-1:0] async_in,
   output logic      [WIDTH-1:0] sync_out
);
   typedef struct packed {
      logic [WIDTH-1:0] meta;
      logic [WIDTH-1:0] stable;
   } pllc_sync_st_s;

   pllc_sync_st_s st_q;
   pllc_sync_st_s st_d;

   if (WIDTH < 1) begin : g_chk
      $error("pllc_sync: WIDTH must be at least 1");
   end

   // the meta stage feeds the stable stage only
   always_comb begin
      st_d        = st_q;
      st_d.meta   = async_in;
      st_d.stable = st_q.meta;
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end

   assign sync_out = st_q.stable;
endmodule : pllc_sync

// file: hw/pllc_phase_det.sv
// phase-frequency detector with lock filter node and open-drain lock drive
`timescale 1ns/10ps
module pllc_phase_det (
   // clock and reset
   input  wire logic clk,
   input  wire logic rst,
   // divider edges, one-cycle pulses
   input  wire logic ref_rise,
   input  wire logic main_rise,
   // detector outputs
   output logic      up_n,
   output logic      down_n,
   output logic      lock_filter,
   output logic      lock_oe
);
   typedef struct packed {
      logic up_n;
      logic down_n;
      logic filter;
      logic ld_oe;
   } pllc_pd_st_s;

   pllc_pd_st_s st_q;
   pllc_pd_st_s st_d;
   logic        up;
   logic        down;

   always_comb begin
      st_d = st_q;
      up   = ~st_q.up_n | ref_rise;
      down = ~st_q.down_n | main_rise;
      // both edges seen: the lagging one ends both pulses
      if (up && down) begin
         up   = 1'b0;
         down = 1'b0;
      end
      st_d.up_n   = ~up;
      st_d.down_n = ~down;
      // filter node is computed from the next pulse values so it never lags them
      st_d.filter = ~(st_d.up_n & st_d.down_n);
      st_d.ld_oe  = st_d.filter;
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         st_q <= '{up_n: 1'b1, down_n: 1'b1, filter: 1'b0, ld_oe: 1'b0};
      end else begin
         st_q <= st_d;
      end
   end

   assign up_n        = st_q.up_n;
   assign down_n      = st_q.down_n;
   assign lock_filter = st_q.filter;
   assign lock_oe     = st_q.ld_oe;

   a_filter_nand: assert property (@(posedge clk) disable iff (rst)
      lock_filter == ~(up_n & down_n)) else $error("filter node is not nand of pulses");
   a_lock_drive: assert property (@(posedge clk) disable iff (rst)
      lock_oe == lock_filter) else $error("lock drive does not follow filter node");
   a_down_pulse: assert property (@(posedge clk) disable iff (rst)
      main_rise && !ref_rise && up_n |=> !down_n) else $error("no down pulse on main lead");
   a_up_pulse: assert property (@(posedge clk) disable iff (rst)
      ref_rise && !main_rise && down_n |=> !up_n) else $error("no up pulse on ref lead");
endmodule : pllc_phase_det

// file: sim/pllc_ctl_model.sv
// controller model: parallel strobes, bus and serial shifting
`timescale 1ns/10ps
module pllc_ctl_model (
   // clock
   input  wire logic clk,
   // pins toward the load port
   output logic [4:0] stb,
   output logic [7:0] data,
   output logic       sload,
   output logic       sclk,
   output logic       sdat
);
   initial begin
      stb   = 5'h00;
      data  = 8'h00;
      sload = 1'h0;
      sclk  = 1'h0;
      sdat  = 1'h0;
   end
   // three clocks between pin changes keep setup, hold and width past the synchroniser
   task automatic gap;
      repeat (3) @(posedge clk);
   endtask : gap
   task automatic pwrite(input logic [2:0] idx, input logic [7:0] v);
      data <= v;
      gap();
      stb[idx] <= 1'h1;
      gap();
      stb[idx] <= 1'h0;
      gap();
      data <= ~v;  // hold time over, bus no longer shows the value
   endtask : pwrite
   task automatic sshift(input int n, input logic [19:0] v);
      for (int i = n - 1; i >= 0; i--) begin
         sdat <= v[i];
         gap();
         sclk <= 1'h1;
         gap();
         sclk <= 1'h0;
      end
      gap();
      sdat <= ~v[0];
   endtask : sshift
   task automatic eshift(input logic [7:0] v);
      stb[3] <= 1'h1;
      gap();
      sshift(8, {12'h000, v});
      stb[3] <= 1'h0;
      gap();
   endtask : eshift
   task automatic spulse;
      sload <= 1'h1;
      gap();
      sload <= 1'h0;
      gap();
   endtask : spulse
endmodule : pllc_ctl_model

// file: sim/tb.sv
// self-checking bench of the counter load port
`timescale 1ns/10ps
module tb;
   typedef struct packed {
      logic [2:0]  idx;
      logic [7:0]  d;
      logic [7:0]  a;
      logic [31:0] e;
   } pllc_row_s;
   logic                clk;
   logic                rst;
   logic                cyc;
   logic                stb;
   logic                we;
   logic [7:0]          adr;
   logic [3:0]          sel;
   logic [31:0]         dat;
   logic [31:0]         rdat;
   logic                ack;
   logic [1:0]          mode;
   logic                enh_n;
   logic                pch;
   logic                sch;
   logic [3:0]          div;
   pllc_pkg::pllc_cfg_s dcfg;
   pllc_pkg::pllc_cfg_s cfg;
   logic [4:0]          pstb;
   logic [7:0]          pdat;
   logic                sload;
   logic                sclk;
   logic                sdat;
   logic [2:0]          mon;
   logic [3:0]          pd;
   logic                ld_o;
   logic [31:0]         q;
   int                  num_errors = 0;
   int                  num_checks = 0;
   int                  cycles = 0;
   pllc_row_s           rows [6];
   pllc_ctl_model ctl (.clk(clk), .stb(pstb), .data(pdat), .sload(sload), .sclk(sclk),
      .sdat(sdat));
   pllc_load_port uut (.clk(clk), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
      .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack),
      .serial_mode_sel(mode[0]), .direct_mode_sel(mode[1]), .enh_mode_n(enh_n),
      .parallel_register_choice(pch), .serial_register_choice(sch),
      .main_count_low_strobe(pstb[0]), .main_count_high_strobe(pstb[1]),
      .swallow_count_strobe(pstb[2]), .enh_write(pstb[3]), .hop_strobe(pstb[4]),
      .par_data(pdat), .serial_load(sload), .shift_clk(sclk), .shift_data(sdat),
      .direct_cfg(dcfg), .main_divider_in(div[3]), .reference_divider_in(div[2]),
      .modulus_select(div[1]), .prescaler_raw(div[0]), .counter_cfg(cfg),
      .main_divider_monitor(mon[2]), .reference_divider_monitor(mon[1]),
      .test_data_out(mon[0]), .phase_up_pulse_n(pd[3]), .phase_down_pulse_n(pd[2]),
      .lock_filter(pd[1]), .lock_indicator_oe(pd[0]), .lock_indicator_o(ld_o));
   task automatic test_done;
      $display("checks %0d errors %0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : test_done
   task automatic check(input logic [31:0] s, input logic [31:0] e);
      num_checks++;
      if (s !== e) begin
         num_errors++;
         $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask : check
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      cyc <= 1'h1;
      stb <= 1'h1;
      we  <= w;
      sel <= 4'hF;
      adr <= a;
      dat <= d;
      do @(posedge clk); while (ack !== 1'h1);
      q = rdat;
      cyc <= 1'h0;
      stb <= 1'h0;
      sel <= 4'h0;
      @(posedge clk);
   endtask : wb
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      wb(1'h0, a, 32'h00000000);
      check(q, e);
   endtask : rd
   // dividers set, then monitors and detector outputs compared once settled
   task automatic pin(input logic [3:0] d, input logic [6:0] e);
      div <= d;
      repeat (6) @(posedge clk);
      check({25'h0000000, mon, pd}, {25'h0000000, e});
   endtask : pin
   initial begin
      clk = 1'h0;
      forever #5 clk = ~clk;
   end
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 30000) begin
         num_errors++;
         test_done();
      end
   end
   initial begin
      rows = '{'{3'h0, 8'hA5, pllc_pkg::OFS_PRIMARY, 32'h00002250},
               '{3'h1, 8'h0B, pllc_pkg::OFS_PRIMARY, 32'h00083A50},
               '{3'h2, 8'h9C, pllc_pkg::OFS_PRIMARY, 32'h000A7A5C},
               '{3'h3, 8'h0F, pllc_pkg::OFS_ENH, 32'h0000000F},
               '{3'h4, 8'h00, pllc_pkg::OFS_SECONDARY, 32'h000A7A5C},
               '{3'h0, 8'h00, pllc_pkg::OFS_PRIMARY, 32'h000A580C}};
      {rst, cyc, stb, we, sel, adr, dat} = {1'h1, 47'h000000000000};
      {mode, enh_n, pch, sch, div, dcfg} = {2'h0, 3'h7, 4'h0, 20'h00000};
      repeat (12) @(posedge clk);
      rst <= 1'h0;
      foreach (rows[i]) begin
         ctl.pwrite(rows[i].idx, rows[i].d);
         rd(rows[i].a, rows[i].e);
      end
      check({12'h000, cfg}, 32'h000A580C);
      pch <= 1'h0;
      repeat (6) @(posedge clk);
      check({12'h000, cfg}, 32'h000A7A5C);
      $display("end of parallel loads");
      pin(4'h4, 7'h27);
      pin(4'hC, 7'h6C);
      pin(4'h0, 7'h0C);
      pin(4'h8, 7'h4B);
      pin(4'hC, 7'h6C);
      check({31'h00000000, ld_o}, 32'h00000000);
      enh_n <= 1'h0;
      pin(4'hD, 7'h1C);
      ctl.pwrite(3'h3, 8'h02);
      pin(4'hE, 7'h7C);
      $display("end of detector and monitors");
      dcfg <= 20'h5A5A5;
      mode <= 2'h2;
      repeat (6) @(posedge clk);
      check({12'h000, cfg}, 32'h0005A5A5);
      ctl.pwrite(3'h0, 8'hFF);
      rd(pllc_pkg::OFS_PRIMARY, 32'h000A580C);
      dcfg <= 20'h0F0F0;
      repeat (6) @(posedge clk);
      check({12'h000, cfg}, 32'h000F0F0);
      rd(pllc_pkg::OFS_ACTIVE, 32'h0000F0F0);
      rd(pllc_pkg::OFS_STATUS, 32'h0000000A);
      $display("end of direct mode");
      mode <= 2'h1;
      repeat (6) @(posedge clk);
      ctl.sshift(20, 20'h12345);
      rd(pllc_pkg::OFS_PRIMARY, 32'h00012345);
      ctl.spulse();
      rd(pllc_pkg::OFS_SECONDARY, 32'h00012345);
      ctl.eshift(8'hC3);
      rd(pllc_pkg::OFS_ENH, 32'h000000C3);
      rd(pllc_pkg::OFS_PRIMARY, 32'h00012345);
      ctl.sshift(20, 20'h0ABCD);
      check({12'h000, cfg}, 32'h0000ABCD);
      sch <= 1'h0;
      repeat (6) @(posedge clk);
      check({12'h000, cfg}, 32'h00012345);
      sch <= 1'h1;
      wb(1'h1, pllc_pkg::OFS_CTRL, 32'h00000001);
      rd(pllc_pkg::OFS_SECONDARY, 32'h0000ABCD);
      rd(pllc_pkg::OFS_CTRL, 32'h00000000);
      rd(8'hFC, 32'h00000000);
      $display("end of serial mode");
      enh_n <= 1'h1;
      pin(4'h0, 7'h0C);
      rst <= 1'h1;
      repeat (12) @(posedge clk);
      rst <= 1'h0;
      rd(pllc_pkg::OFS_PRIMARY, 32'h00000000);
      rd(pllc_pkg::OFS_ENH, 32'h00000000);
      rd(pllc_pkg::OFS_STATUS, 32'h00000009);
      check({12'h000, cfg}, 32'h00000000);
      check({25'h0000000, mon, pd}, 32'h0000000C);
      $display("end of second reset");
      test_done();
   end
endmodule : tb
